// >>> design/adcsp_pkg.sv
// shared constants and types for the converter serial register port
package adcsp_pkg;

	// frame geometry
	localparam int           CMD_BITS   = 8;
	localparam int           WORD_BITS  = 24;
	localparam int           SETUP_BITS = 12;
	localparam int           NUM_CSR    = 8;
	localparam logic [4:0]   CMD_LAST   = 5'h07;
	localparam logic [4:0]   WORD_LAST  = 5'h17;

	// command bytes
	localparam logic [7:0]   CMD_WR_OFFSET1 = 8'h01;
	localparam logic [7:0]   CMD_WR_GAIN1   = 8'h02;
	localparam logic [7:0]   CMD_WR_CONFIG  = 8'h03;
	localparam logic [7:0]   CMD_WR_CSR     = 8'h05;
	localparam logic [7:0]   CMD_RD_OFFSET1 = 8'h09;
	localparam logic [7:0]   CMD_RD_GAIN1   = 8'h0A;
	localparam logic [7:0]   CMD_RD_CONFIG  = 8'h0B;
	localparam logic [7:0]   CMD_RD_CSR     = 8'h0D;

	// configuration register depth pointer field
	localparam int           DEPTH_LSB = 0;
	localparam int           DEPTH_W   = 4;

	// setup field layout, msb first
	localparam int           LATCH_LSB = 10;
	localparam int           CHAN_LSB  = 7;
	localparam int           RATE_LSB  = 4;
	localparam int           GAIN_LSB  = 1;
	localparam int           POL_BIT   = 0;
	localparam logic [23:0]  CSR_RESET = 24'h000000;
	localparam logic [23:0]  REG_RESET = 24'h000000;

	// host side: link timing and register map
	localparam int           CORE_CLK_MHZ  = 40;
	localparam int           SCLK_HALF_NS  = 100;
	localparam int           SCLK_HALF_CYC = (SCLK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam logic [3:0]   HADDR_CTRL    = 4'h0;
	localparam logic [3:0]   HADDR_STATUS  = 4'h1;
	localparam int           HADDR_DATA_BIT = 3;
	localparam int           CTRL_CNT_LSB  = 8;

	typedef enum logic [1:0] {adcsp_cmd, adcsp_wr, adcsp_rd} adcsp_state_type;
	typedef enum logic [2:0] {
		adcsp_none, adcsp_offset1, adcsp_gain1, adcsp_config, adcsp_csr
	} adcsp_sel_type;
	typedef enum logic [2:0] {adcsp_idle, adcsp_lead, adcsp_hi, adcsp_lo, adcsp_tail} adcsp_hstate_type;

endpackage : adcsp_pkg

// >>> design/adcsp_link_if.sv
// four-line serial link between host and converter port
`timescale 1ns/1ps
`default_nettype none
interface adcsp_link_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo_out;
	logic sdo_oe;
	wire  sdo;

	// released line shows the inverse of the last bit, so a sample taken while released is caught
	assign sdo = sdo_oe ? sdo_out : ~sdo_out;

	modport dev (input cs_n, input sclk, input sdi, output sdo_out, output sdo_oe);
	modport host (output cs_n, output sclk, output sdi, input sdo);
endinterface : adcsp_link_if
`default_nettype wire

// >>> design/adcsp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module adcsp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rstn,
	// async in, synced out
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : adcsp_sync
`default_nettype wire

// >>> design/adcsp_dev.sv
// Contract
// - output floats while chip select high
// - clock edges ignored while deselected
// - works with chip select tied low
// - host serial clock alone times bits
// - register write is command plus 24 bits
// - command 0x02 writes channel-one gain
// - command 0x0A reads channel-one gain
// - back to command after single register
// - eight setup pair registers, two setups
// - latch pins follow active setup top bits
// - setups define later conversion mode
// - host programs depth pointer first
// - 0x05 writes pairs covered by depth
// - 0x0D reads pairs covered by depth
// - depth 0001 one pair, 0011 two
// - pairs always move as 24 bits
// - host uses only odd depth values
// - back to command after last pair
// - reset word rate is slowest default
`timescale 1ns/1ps
`default_nettype none
module adcsp_dev
	import adcsp_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rstn,
	// serial link
	adcsp_link_if.dev       link,
	// setup selection from conversion logic
	input  wire logic [3:0] active_setup,
	// active setup mode
	output var  logic [1:0] latch_output_pins,
	output var  logic [2:0] input_channel_field,
	output var  logic [2:0] word_rate_field,
	output var  logic [2:0] gain_range_field,
	output var  logic       polarity
);
	typedef struct packed {
		adcsp_state_type                 st;
		adcsp_sel_type                   sel;
		logic [WORD_BITS-1:0]            sh;
		logic [4:0]                      cnt;
		logic [2:0]                      idx;
		logic [WORD_BITS-1:0]            offset1;
		logic [WORD_BITS-1:0]            gain1;
		logic [WORD_BITS-1:0]            config_reg;
		logic [NUM_CSR-1:0][WORD_BITS-1:0] channel_setup_pair;
		logic                            sclk_prev;
		logic                            sdo;
		logic                            sdo_oe;
		logic [SETUP_BITS-1:0]           setup;
	} adcsp_dev_type;

	adcsp_dev_type r;
	adcsp_dev_type next_r;
	logic [2:0]    pins;
	logic          cs_n_s;
	logic          sclk_s;
	logic          sdi_s;

	adcsp_sync #(.W(3)) u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.d        ({~link.cs_n, link.sclk, link.sdi}),
		.q        (pins)
	);
	// sync resets to zero, so select travels inverted and reset reads as deselected
	assign cs_n_s = !pins[2];
	assign sclk_s = pins[1];
	assign sdi_s  = pins[0];

	function automatic adcsp_sel_type cmd_sel(input logic [7:0] c);
		unique case (c)
			CMD_WR_OFFSET1, CMD_RD_OFFSET1: cmd_sel = adcsp_offset1;
			CMD_WR_GAIN1, CMD_RD_GAIN1:     cmd_sel = adcsp_gain1;
			CMD_WR_CONFIG, CMD_RD_CONFIG:   cmd_sel = adcsp_config;
			CMD_WR_CSR, CMD_RD_CSR:         cmd_sel = adcsp_csr;
			default:                        cmd_sel = adcsp_none;
		endcase
	endfunction : cmd_sel

	function automatic logic [WORD_BITS-1:0] rd_word(input adcsp_dev_type s,
			input adcsp_sel_type sel, input logic [2:0] i);
		unique case (sel)
			adcsp_offset1: rd_word = s.offset1;
			adcsp_gain1:   rd_word = s.gain1;
			adcsp_config:  rd_word = s.config_reg;
			adcsp_csr:     rd_word = s.channel_setup_pair[i];
			default:       rd_word = '0;
		endcase
	endfunction : rd_word

	logic       rise;
	logic       fall;
	logic [2:0] last_idx;
	logic [7:0] cmd_byte;
	logic [WORD_BITS-1:0] word_in;
	logic [WORD_BITS-1:0] pair;

	assign last_idx = r.config_reg[DEPTH_LSB+1 +: 3];
	assign rise     = !cs_n_s && sclk_s && !r.sclk_prev;
	assign fall     = !cs_n_s && !sclk_s && r.sclk_prev;
	assign cmd_byte = {r.sh[CMD_BITS-2:0], sdi_s};
	assign word_in  = {r.sh[WORD_BITS-2:0], sdi_s};
	assign pair     = r.channel_setup_pair[active_setup[3:1]];

	always_comb begin
		next_r = r;
		next_r.sclk_prev = sclk_s;
		next_r.sdo_oe = !cs_n_s;
		next_r.setup = active_setup[0] ? pair[SETUP_BITS-1:0] : pair[WORD_BITS-1:SETUP_BITS];
		if (cs_n_s) begin
			// deselect aborts the frame
			next_r.st  = adcsp_cmd;
			next_r.cnt = '0;
			next_r.sh  = '0;
		end else if (rise) begin
			next_r.cnt = r.cnt + 5'h01;
			unique case (r.st)
				adcsp_cmd: begin
					next_r.sh = {{(WORD_BITS-CMD_BITS){1'b0}}, cmd_byte};
					if (r.cnt == CMD_LAST) begin
						next_r.cnt = '0;
						next_r.idx = '0;
						next_r.sel = cmd_sel(cmd_byte);
						if (cmd_sel(cmd_byte) == adcsp_none) begin
							next_r.st = adcsp_cmd;
						end else if (cmd_byte[3]) begin
							next_r.st = adcsp_rd;
							next_r.sh = rd_word(r, cmd_sel(cmd_byte), 3'h0);
						end else begin
							next_r.st = adcsp_wr;
						end
					end
				end
				adcsp_wr: begin
					next_r.sh = word_in;
					if (r.cnt == WORD_LAST) begin
						next_r.cnt = '0;
						next_r.st  = adcsp_cmd;
						unique case (r.sel)
							adcsp_offset1: next_r.offset1 = word_in;
							adcsp_gain1:   next_r.gain1 = word_in;
							adcsp_config:  next_r.config_reg = word_in;
							default: begin
								next_r.channel_setup_pair[r.idx] = word_in;
								if (r.idx != last_idx) begin
									next_r.idx = r.idx + 3'h1;
									next_r.st  = adcsp_wr;
								end
							end
						endcase
					end
				end
				adcsp_rd: begin
					if (r.cnt == WORD_LAST) begin
						next_r.cnt = '0;
						next_r.st  = adcsp_cmd;
						if (r.sel == adcsp_csr && r.idx != last_idx) begin
							next_r.idx = r.idx + 3'h1;
							next_r.st  = adcsp_rd;
							next_r.sh  = r.channel_setup_pair[r.idx + 3'h1];
						end
					end
				end
				default: next_r.st = adcsp_cmd;
			endcase
		end else if (fall && r.st == adcsp_rd) begin
			// read data changes on falling edge
			next_r.sdo = r.sh[WORD_BITS-1];
			next_r.sh  = {r.sh[WORD_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			r <= '{
				st: adcsp_cmd, sel: adcsp_none, sh: '0, cnt: '0, idx: '0,
				offset1: REG_RESET, gain1: REG_RESET, config_reg: REG_RESET,
				channel_setup_pair: {NUM_CSR{CSR_RESET}},
				sclk_prev: 1'b0, sdo: 1'b0, sdo_oe: 1'b0, setup: '0
			};
		end else begin
			r <= next_r;
		end
	end

	assign link.sdo_out = r.sdo;
	assign link.sdo_oe  = r.sdo_oe;

	assign latch_output_pins   = r.setup[LATCH_LSB +: 2];
	assign input_channel_field = r.setup[CHAN_LSB +: 3];
	assign word_rate_field     = r.setup[RATE_LSB +: 3];
	assign gain_range_field    = r.setup[GAIN_LSB +: 3];
	assign polarity            = r.setup[POL_BIT];
endmodule : adcsp_dev
`default_nettype wire

// >>> design/adcsp_host.sv
// host end: runs one command frame from software registers
`timescale 1ns/1ps
`default_nettype none
module adcsp_host
	import adcsp_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// software register port
	input  wire logic [3:0]  addr,
	input  wire logic [23:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output var  logic [23:0] rdata,
	// serial link
	adcsp_link_if.host       link
);
	typedef struct packed {
		adcsp_hstate_type              st;
		logic [7:0]                    div;
		logic [WORD_BITS-1:0]          sh;
		logic [WORD_BITS-1:0]          rsh;
		logic [4:0]                    cnt;
		logic [3:0]                    unit;
		logic [3:0]                    nwords;
		logic [NUM_CSR-1:0][WORD_BITS-1:0] word;
		logic                          cs_n;
		logic                          sclk;
		logic                          sdi;
		logic [23:0]                   rdata;
	} adcsp_host_type;

	adcsp_host_type r;
	adcsp_host_type next_r;
	logic           sdo_s;
	logic           half_done;
	logic [4:0]     unit_last;

	adcsp_sync #(.W(1)) u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.d        (link.sdo),
		.q        (sdo_s)
	);

	assign half_done = r.div == 8'(SCLK_HALF_CYC - 1);
	assign unit_last = (r.unit == 4'h0) ? CMD_LAST : WORD_LAST;

	always_comb begin
		next_r = r;
		next_r.div = half_done ? 8'h00 : r.div + 8'h01;
		next_r.rdata = '0;
		if (rd) begin
			if (addr == HADDR_STATUS) begin
				next_r.rdata = {23'h000000, r.st != adcsp_idle};
			end else if (addr[HADDR_DATA_BIT]) begin
				next_r.rdata = r.word[addr[2:0]];
			end
		end
		if (wr && addr[HADDR_DATA_BIT] && r.st == adcsp_idle) begin
			next_r.word[addr[2:0]] = wdata;
		end
		unique case (r.st)
			adcsp_idle: begin
				next_r.div = '0;
				if (wr && addr == HADDR_CTRL) begin
					next_r.st     = adcsp_lead;
					next_r.cs_n   = 1'b0;
					next_r.sdi    = wdata[CMD_BITS-1];
					next_r.sh     = {wdata[CMD_BITS-2:0], {(WORD_BITS-CMD_BITS+1){1'b0}}};
					next_r.nwords = wdata[CTRL_CNT_LSB +: 4];
					next_r.unit   = '0;
					next_r.cnt    = '0;
				end
			end
			adcsp_lead, adcsp_lo: begin
				if (half_done) begin
					next_r.st   = adcsp_hi;
					next_r.sclk = 1'b1;
					next_r.cnt  = r.cnt + 5'h01;
					if (r.cnt == unit_last) begin
						next_r.cnt  = '0;
						next_r.unit = r.unit + 4'h1;
						next_r.sh   = r.word[3'(r.unit)];
					end
				end
			end
			adcsp_hi: begin
				if (half_done) begin
					next_r.sclk = 1'b0;
					// sample late in the high phase: the two synchronisers put five cycles between
					// our falling edge and the answer, more than one half period
					next_r.rsh  = {r.rsh[WORD_BITS-2:0], sdo_s};
					// cnt is zero only after a rise that closed a unit
					if (r.cnt == 5'h00 && r.unit > 4'h1) begin
						next_r.word[3'(r.unit - 4'h2)] = {r.rsh[WORD_BITS-2:0], sdo_s};
					end
					if (r.unit > r.nwords) begin
						next_r.st = adcsp_tail;
					end else begin
						// falling edge: next bit out
						next_r.st  = adcsp_lo;
						next_r.sdi = r.sh[WORD_BITS-1];
						next_r.sh  = {r.sh[WORD_BITS-2:0], 1'b0};
					end
				end
			end
			adcsp_tail: begin
				if (half_done) begin
					next_r.st   = adcsp_idle;
					next_r.cs_n = 1'b1;
				end
			end
			default: next_r.st = adcsp_idle;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			r <= '{
				st: adcsp_idle, div: '0, sh: '0, rsh: '0, cnt: '0, unit: '0,
				nwords: '0, word: '0, cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0, rdata: '0
			};
		end else begin
			r <= next_r;
		end
	end

	assign link.cs_n = r.cs_n;
	assign link.sclk = r.sclk;
	assign link.sdi  = r.sdi;
	assign rdata     = r.rdata;
endmodule : adcsp_host
`default_nettype wire

// >>> tb/adcsp_monitor.sv
// link checker for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module adcsp_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo_out,
	input wire logic sdo_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// clock rises in the open frame; cleared while deselected
	logic [7:0] rises;
	always_ff @(posedge core_clk) begin
		if (!rstn || cs_n) begin
			rises <= 8'h00;
		end else if ($rose(sclk)) begin
			rises <= rises + 8'h01;
		end
	end

	// enable lags select through the synchroniser, so allow six cycles
	a_float_when_idle: assert property (cs_n [*6] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	a_oe_follows_select: assert property ($fell(cs_n) |-> ##[1:6] sdo_oe)
		else $error("sdo not enabled after select");
	a_clock_quiet_idle: assert property (cs_n |-> !sclk)
		else $error("sclk high while deselected");
	a_clock_lead_low: assert property ($fell(cs_n) |-> !sclk [*4])
		else $error("sclk moved too soon after select");
	a_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("sclk high phase not four cycles");
	a_sdi_hold_high: assert property ($rose(sclk) |=> $stable(sdi) [*3])
		else $error("sdi changed while sclk high");
	a_sdo_hold_high: assert property (sdo_oe && $rose(sclk) |=> $stable(sdo_out) [*3])
		else $error("sdo changed while sclk high");
	a_frame_whole_words: assert property ($rose(cs_n) |->
		rises >= 8'h08 && (rises - 8'h08) % 8'h18 == 8'h00)
		else $error("frame not command plus whole words");

	c_single_word: cover property ($rose(cs_n) && rises == 8'h20);
	c_two_pairs: cover property ($rose(cs_n) && rises == 8'h38);
	c_read_bits: cover property (sdo_oe && $rose(sclk) && rises > 8'h08);
endmodule : adcsp_monitor
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench: host end and converter end joined by the link
`timescale 1ns/1ps
`default_nettype none
module tb
	import adcsp_pkg::*;
;
	logic        core_clk;
	logic        rstn;
	logic [3:0]  addr;
	logic [23:0] wdata;
	logic        wr;
	logic        rd;
	logic [23:0] rdata;
	logic [3:0]  active_setup;
	logic [1:0]  latch_output_pins;
	logic [2:0]  input_channel_field;
	logic [2:0]  word_rate_field;
	logic [2:0]  gain_range_field;
	logic        polarity;
	logic [23:0] d;
	int          fails;
	int          n_tests;

	adcsp_link_if link ();
	adcsp_host adcsp_host_inst (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .link(link));
	adcsp_dev adcsp_dev_inst (.core_clk(core_clk), .rstn(rstn), .link(link), .active_setup(active_setup),
		.latch_output_pins(latch_output_pins), .input_channel_field(input_channel_field),
		.word_rate_field(word_rate_field), .gain_range_field(gain_range_field), .polarity(polarity));
	adcsp_monitor adcsp_monitor_inst (.core_clk(core_clk), .rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
		.sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input logic [23:0] v);
		@(posedge core_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [23:0] v);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		@(negedge core_clk);
		v = rdata;
	endtask : rd_reg

	// start a frame and poll busy; first poll skipped as busy may land late
	task automatic frame(input logic [23:0] ctrl);
		int i;
		wr_reg(HADDR_CTRL, ctrl);
		for (i = 0; i < 3000; i++) begin
			rd_reg(HADDR_STATUS, d);
			if (i > 0 && d[0] === 1'b0) break;
		end
		if (i == 3000) begin
			fails++;
			tally_and_finish();
		end
	endtask : frame

	task automatic setup_chk(input logic [3:0] s, input logic [23:0] pair);
		@(posedge core_clk);
		active_setup <= s;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk({12'h000, latch_output_pins, input_channel_field, word_rate_field, gain_range_field, polarity},
			{12'h000, s[0] ? pair[11:0] : pair[23:12]});
	endtask : setup_chk

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		rstn = 1'b0;
		addr = 4'h0;
		wdata = 24'h000000;
		wr = 1'b0;
		rd = 1'b0;
		active_setup = 4'h0;
		fails = 0;
		n_tests = 0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		@(negedge core_clk);
		chk({21'h0, word_rate_field}, 24'h000000);
		wr_reg(4'h8, 24'h800000);
		frame({12'h000, 4'h1, CMD_WR_GAIN1});
		wr_reg(4'h8, 24'h123456);
		frame({12'h000, 4'h1, CMD_RD_GAIN1});
		rd_reg(4'h8, d);
		chk(d, 24'h800000);
		wr_reg(4'h8, 24'h000003);
		frame({12'h000, 4'h1, CMD_WR_CONFIG});
		wr_reg(4'h8, 24'hA5C3F1);
		wr_reg(4'h9, 24'h3C6E97);
		frame({12'h000, 4'h2, CMD_WR_CSR});
		wr_reg(4'h8, 24'h000000);
		wr_reg(4'h9, 24'h000000);
		frame({12'h000, 4'h2, CMD_RD_CSR});
		rd_reg(4'h8, d);
		chk(d, 24'hA5C3F1);
		rd_reg(4'h9, d);
		chk(d, 24'h3C6E97);
		for (int s = 0; s < 4; s++) begin
			setup_chk(4'(s), s < 2 ? 24'hA5C3F1 : 24'h3C6E97);
		end
		// depth one must leave the second pair alone
		wr_reg(4'h8, 24'h000001);
		frame({12'h000, 4'h1, CMD_WR_CONFIG});
		wr_reg(4'h8, 24'h5A5A5A);
		frame({12'h000, 4'h1, CMD_WR_CSR});
		wr_reg(4'h8, 24'h000003);
		frame({12'h000, 4'h1, CMD_WR_CONFIG});
		wr_reg(4'h9, 24'h000000);
		frame({12'h000, 4'h2, CMD_RD_CSR});
		rd_reg(4'h8, d);
		chk(d, 24'h5A5A5A);
		rd_reg(4'h9, d);
		chk(d, 24'h3C6E97);
		rd_reg(4'h2, d);
		chk(d, 24'h000000);
		wr_reg(4'h8, 24'h000000);
		frame({12'h000, 4'h1, CMD_RD_CONFIG});
		rd_reg(4'h8, d);
		chk(d, 24'h000003);
		// offset write, then a read command chained in the same frame, cut after 16 bits
		wr_reg(4'h8, 24'h3A5C7E);
		wr_reg(4'h9, {CMD_RD_OFFSET1, 16'h0000});
		frame({12'h000, 4'h2, CMD_WR_OFFSET1});
		rd_reg(4'h9, d);
		chk({8'h00, d[15:0]}, 24'h003A5C);
		wr_reg(4'h8, 24'h000000);
		frame({12'h000, 4'h1, CMD_RD_OFFSET1});
		rd_reg(4'h8, d);
		chk(d, 24'h3A5C7E);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
